/* rtl/rmc_config_bank.sv */
`timescale 1ns/10ps
// Contract
// - A set power-saving bit turns unused radio circuitry off; a clear one leaves it on.
// - Power-saving writes land only while the analog write enable is one.
// - A set carrier-detect override bit forces the carrier-detect indication active.
// - Carrier-detect override writes land only while the analog write enable is one.
// - The lock wait lasts the eight-bit count times two microseconds before lock is shown.
// - The count is used only in automatic synthesizer mode without the PLL lock signal.
// - The lock delay count resets to 0x64.
// - The top two bits of the serial identifier always read zero.
// - The 30 identifier bits read out only while the identifier read enable is set.
// - The identifier bytes are read-only and writes leave them unchanged.
module rmc_config_bank #(
	parameter logic [15:0] LOCK_STEP_CYCLES = 16'(rmc_pkg::LOCK_STEP_CYCLES)
) (
	input  wire logic                 clock_i,
	input  wire logic                 reset_i,
	input  wire rmc_pkg::rmc_req_t    req_i,
	input  wire rmc_pkg::rmc_analog_t analog_i,
	input  wire logic                 manual_synth_i,
	input  wire logic                 pll_lock_used_i,
	input  wire logic                 pll_lock_i,
	input  wire logic                 synth_start_i,
	input  wire logic                 carrier_detect_raw_i,
	input  wire logic [29:0]          serial_id_i,
	output logic [7:0]                rd_data_o,
	output logic                      rd_valid_o,
	output logic                      power_save_o,
	output logic                      carrier_detect_o,
	output logic [7:0]                clock_override_o,
	output logic [7:0]                clock_enable_o,
	output logic [7:0]                lock_delay_o,
	output logic                      synth_locked_o
);

	// ======================================================================
	// Request decode.
	logic        wr_ps;
	logic        wr_cd;
	logic        wr_co;
	logic        wr_ce;
	logic        wr_ld;
	logic        carrier_force;
	logic [31:0] id_word;
	logic [7:0]  next_rd_data;

	assign wr_ps = req_i.wr && (req_i.addr == rmc_pkg::ADDR_POWER_SAVING);
	assign wr_cd = req_i.wr && (req_i.addr == rmc_pkg::ADDR_CARRIER_DETECT);
	assign wr_co = req_i.wr && (req_i.addr == rmc_pkg::ADDR_CLOCK_OVERRIDE);
	assign wr_ce = req_i.wr && (req_i.addr == rmc_pkg::ADDR_CLOCK_ENABLE);
	assign wr_ld = req_i.wr && (req_i.addr == rmc_pkg::ADDR_LOCK_DELAY);

	// The top two identifier bits are hard zero.
	assign id_word = {2'h0, serial_id_i};

	// ======================================================================
	// Gated configuration bits. Only bit 7 is stored, so reserved bits cannot hold data.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			power_save_o <= rmc_pkg::RESET_POWER_SAVING;
		end else if (wr_ps && analog_i.write_en) begin
			power_save_o <= req_i.wdata[rmc_pkg::POWER_SAVING_BIT];
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			carrier_force <= rmc_pkg::RESET_CARRIER_FORCE;
		end else if (wr_cd && analog_i.write_en) begin
			carrier_force <= req_i.wdata[rmc_pkg::CARRIER_FORCE_BIT];
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			carrier_detect_o <= 1'h0;
		end else begin
			carrier_detect_o <= carrier_force | carrier_detect_raw_i;
		end
	end

	// ======================================================================
	// Clock override pair. Both must be loaded by software after reset.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			clock_override_o <= rmc_pkg::RESET_CLOCK_OVERRIDE;
		end else if (wr_co) begin
			clock_override_o <= req_i.wdata;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			clock_enable_o <= rmc_pkg::RESET_CLOCK_ENABLE;
		end else if (wr_ce) begin
			clock_enable_o <= req_i.wdata;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			lock_delay_o <= rmc_pkg::RESET_LOCK_DELAY;
		end else if (wr_ld) begin
			lock_delay_o <= req_i.wdata;
		end
	end

	// ======================================================================
	// Read port. Identifier addresses never decode as writes, so they stay read-only.
	always_comb begin
		next_rd_data = 8'h00;
		if (req_i.addr == rmc_pkg::ADDR_POWER_SAVING) begin
			next_rd_data = {power_save_o, 7'h00};
		end else if (req_i.addr == rmc_pkg::ADDR_CARRIER_DETECT) begin
			next_rd_data = {carrier_force, 7'h00};
		end else if (req_i.addr == rmc_pkg::ADDR_CLOCK_OVERRIDE) begin
			next_rd_data = clock_override_o;
		end else if (req_i.addr == rmc_pkg::ADDR_CLOCK_ENABLE) begin
			next_rd_data = clock_enable_o;
		end else if (req_i.addr == rmc_pkg::ADDR_LOCK_DELAY) begin
			next_rd_data = lock_delay_o;
		end else if (!analog_i.id_read_en) begin
			next_rd_data = 8'h00;
		end else if (req_i.addr == rmc_pkg::ADDR_SERIAL_ID_B0) begin
			next_rd_data = id_word[7:0];
		end else if (req_i.addr == rmc_pkg::ADDR_SERIAL_ID_B1) begin
			next_rd_data = id_word[15:8];
		end else if (req_i.addr == rmc_pkg::ADDR_SERIAL_ID_B2) begin
			next_rd_data = id_word[23:16];
		end else if (req_i.addr == rmc_pkg::ADDR_SERIAL_ID_B3) begin
			next_rd_data = id_word[31:24];
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			rd_data_o  <= 8'h00;
			rd_valid_o <= 1'h0;
		end else begin
			rd_valid_o <= req_i.rd;
			if (req_i.rd) begin
				rd_data_o <= next_rd_data;
			end
		end
	end

	// ======================================================================
	// Synthesizer lock. The PLL lock is analog, so it is synchronised first.
	logic pll_meta;
	logic pll_sync;
	logic timer_mode;
	logic timer_done;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			pll_meta <= 1'h0;
			pll_sync <= 1'h0;
		end else begin
			pll_meta <= pll_lock_i;
			pll_sync <= pll_meta;
		end
	end

	assign timer_mode = !manual_synth_i && !pll_lock_used_i;

	rmc_lock_timer #(
		.STEP_CYCLES (LOCK_STEP_CYCLES)
	) u_lock_timer (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.start_i (synth_start_i),
		.count_i (lock_delay_o),
		.done_o  (timer_done)
	);

	// In timer mode a restart drops lock on the next edge so a stale lock never leaks into a retune; the PLL path ignores restarts.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			synth_locked_o <= 1'h0;
		end else if (timer_mode) begin
			synth_locked_o <= timer_done && !synth_start_i;
		end else begin
			synth_locked_o <= pll_sync;
		end
	end

	// ======================================================================
	// Checks.
	logic [15:0] elapsed;
	logic [7:0]  started_count;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			elapsed       <= 16'h0000;
			started_count <= 8'h00;
		end else if (synth_start_i) begin
			elapsed       <= 16'h0000;
			started_count <= lock_delay_o;
		end else if (elapsed != 16'hffff) begin
			elapsed <= elapsed + 16'h0001;
		end
	end

	a_ps_write_taken: assert property (@(posedge clock_i) disable iff (reset_i)
		wr_ps && analog_i.write_en |=> power_save_o == $past(req_i.wdata[7]))
		else $error("power-saving write not taken");
	a_ps_write_gated: assert property (@(posedge clock_i) disable iff (reset_i)
		wr_ps && !analog_i.write_en |=> $stable(power_save_o))
		else $error("power-saving write not blocked");
	a_cd_write_gated: assert property (@(posedge clock_i) disable iff (reset_i)
		wr_cd && !analog_i.write_en
		|=> $stable(carrier_force))
		else $error("carrier override write not blocked");
	a_cd_force_on: assert property (@(posedge clock_i) disable iff (reset_i)
		carrier_force |=> carrier_detect_o)
		else $error("carrier detect not forced");
	a_reset_values: assert property (@(posedge clock_i) disable iff (reset_i)
		$fell(reset_i) |-> clock_override_o == 8'h00 && clock_enable_o == 8'h00
		&& lock_delay_o == 8'h64)
		else $error("wrong reset value");
	a_lock_delay_len: assert property (@(posedge clock_i) disable iff (reset_i)
		$rose(timer_done) && !$past(synth_start_i)
		|-> elapsed == 16'(started_count) * LOCK_STEP_CYCLES)
		else $error("lock delay length wrong");
	a_lock_mode_sel: assert property (@(posedge clock_i) disable iff (reset_i)
		$past(!timer_mode) && !timer_mode |-> synth_locked_o == $past(pll_sync))
		else $error("lock source wrong outside timer mode");
	a_id_top_zero: assert property (@(posedge clock_i) disable iff (reset_i)
		req_i.rd && req_i.addr == rmc_pkg::ADDR_SERIAL_ID_B3 |=> rd_data_o[7:6] == 2'h0)
		else $error("identifier top bits not zero");
	a_id_read_gated: assert property (@(posedge clock_i) disable iff (reset_i)
		req_i.rd && req_i.addr >= rmc_pkg::ADDR_SERIAL_ID_B0 && !analog_i.id_read_en
		|=> rd_valid_o && rd_data_o == 8'h00)
		else $error("identifier readable while disabled");
	a_id_low_byte: assert property (@(posedge clock_i) disable iff (reset_i)
		req_i.rd && req_i.addr == rmc_pkg::ADDR_SERIAL_ID_B0 && analog_i.id_read_en
		|=> rd_data_o == $past(serial_id_i[7:0]))
		else $error("identifier low byte wrong");
	a_reserved_zero: assert property (@(posedge clock_i) disable iff (reset_i)
		req_i.rd && req_i.addr == rmc_pkg::ADDR_POWER_SAVING |=> rd_data_o[6:0] == 7'h00)
		else $error("reserved bits not zero");

	c_ps_set: cover property (@(posedge clock_i) disable iff (reset_i)
		wr_ps && analog_i.write_en && req_i.wdata[7]);
	c_id_read: cover property (@(posedge clock_i) disable iff (reset_i)
		req_i.rd && req_i.addr == rmc_pkg::ADDR_SERIAL_ID_B3 && analog_i.id_read_en);
	c_lock_done: cover property (@(posedge clock_i) disable iff (reset_i)
		timer_mode && $rose(synth_locked_o));
	c_cd_forced: cover property (@(posedge clock_i) disable iff (reset_i)
		carrier_force && !carrier_detect_raw_i ##1 carrier_detect_o);

endmodule : rmc_config_bank

/* rtl/rmc_pkg.sv */
// ==========================================================================
// Shared constants and types for the miscellaneous configuration bank.
package rmc_pkg;

	// ======================================================================
	// Register offsets.
	localparam logic [5:0] ADDR_POWER_SAVING   = 6'h2e;
	localparam logic [5:0] ADDR_CARRIER_DETECT = 6'h2f;
	localparam logic [5:0] ADDR_CLOCK_OVERRIDE = 6'h32;
	localparam logic [5:0] ADDR_CLOCK_ENABLE   = 6'h33;
	localparam logic [5:0] ADDR_LOCK_DELAY     = 6'h38;
	localparam logic [5:0] ADDR_SERIAL_ID_B0   = 6'h3c;
	localparam logic [5:0] ADDR_SERIAL_ID_B1   = 6'h3d;
	localparam logic [5:0] ADDR_SERIAL_ID_B2   = 6'h3e;
	localparam logic [5:0] ADDR_SERIAL_ID_B3   = 6'h3f;

	// ======================================================================
	// Field positions.
	localparam int POWER_SAVING_BIT    = 7;
	localparam int CARRIER_FORCE_BIT   = 7;
	localparam int SERIAL_ID_WIDTH     = 30;
	localparam logic [7:0] RESERVED_LOW7_MASK = 8'h80;

	// ======================================================================
	// Reset values.
	localparam logic       RESET_POWER_SAVING   = 1'h0;
	localparam logic       RESET_CARRIER_FORCE  = 1'h0;
	localparam logic [7:0] RESET_CLOCK_OVERRIDE = 8'h00;
	localparam logic [7:0] RESET_CLOCK_ENABLE   = 8'h00;
	localparam logic [7:0] RESET_LOCK_DELAY     = 8'h64;

	// ======================================================================
	// Timing.
	localparam int CLOCK_PERIOD_NS   = 40;
	localparam int LOCK_STEP_US      = 2;
	localparam int LOCK_STEP_CYCLES  = (LOCK_STEP_US * 1000 + CLOCK_PERIOD_NS - 1)
		/ CLOCK_PERIOD_NS;

	// ======================================================================
	// Carriers.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} rmc_req_t;

	typedef struct packed {
		logic write_en;
		logic id_read_en;
	} rmc_analog_t;

endpackage : rmc_pkg

/* rtl/rmc_lock_timer.sv */
`timescale 1ns/10ps
// ==========================================================================
// Lock delay timer: counts whole steps after each start.
module rmc_lock_timer #(
	parameter logic [15:0] STEP_CYCLES = 16'h0032
) (
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	input  wire logic       start_i,
	input  wire logic [7:0] count_i,
	output logic            done_o
);

	typedef enum logic [2:0] {
		RMC_T_IDLE   = 3'b001,
		RMC_T_WAIT   = 3'b010,
		RMC_T_LOCKED = 3'b100
	} rmc_timer_state_t;

	rmc_timer_state_t state;
	logic [15:0]      prescale;
	logic [7:0]       remaining;

	// ======================================================================
	// Sequencer. A new start always restarts the wait, even mid-count.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state     <= RMC_T_IDLE;
			prescale  <= 16'h0000;
			remaining <= 8'h00;
		end else if (start_i) begin
			prescale  <= 16'h0000;
			remaining <= count_i;
			state     <= (count_i == 8'h00) ? RMC_T_LOCKED : RMC_T_WAIT;
		end else begin
			case (state)
				RMC_T_IDLE: begin
					state <= RMC_T_IDLE;
				end
				RMC_T_WAIT: begin
					if (prescale == STEP_CYCLES - 16'h0001) begin
						prescale <= 16'h0000;
						if (remaining == 8'h01) begin
							state <= RMC_T_LOCKED;
						end else begin
							remaining <= remaining - 8'h01;
						end
					end else begin
						prescale <= prescale + 16'h0001;
					end
				end
				RMC_T_LOCKED: begin
					state <= RMC_T_LOCKED;
				end
				default: begin
					state <= RMC_T_IDLE;
				end
			endcase
		end
	end

	assign done_o = (state == RMC_T_LOCKED);

endmodule : rmc_lock_timer

/* tb/rmc_host_model.sv */
`timescale 1ns/10ps
// ==========================================================================
// Host side: register strobes plus the analog control levels it owns.
module rmc_host_model (
	input  wire logic            clock_i,
	input  wire logic [7:0]      rd_data_i,
	input  wire logic            rd_valid_i,
	output rmc_pkg::rmc_req_t    req_o,
	output rmc_pkg::rmc_analog_t analog_o
);
	initial begin
		req_o = '0;
		analog_o = '0;
	end
	// Released address and data are inverted so a stale value is never mistaken for a live one.
	task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [8:0] got);
		@(posedge clock_i);
		#1;
		req_o = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clock_i);
		#1;
		got = {rd_valid_i, rd_data_i};
		req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : access
	task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
		logic [8:0] unused;
		access(1'b1, a, d, unused);
	endtask : write_reg
	task automatic read_reg(input logic [5:0] a, output logic [8:0] got);
		access(1'b0, a, 8'h00, got);
	endtask : read_reg
	task automatic set_analog(input logic we, input logic idre);
		@(posedge clock_i);
		#1;
		analog_o = '{write_en: we, id_read_en: idre};
	endtask : set_analog
	task automatic init_after_reset();
		set_analog(1'b1, 1'b0);
		write_reg(rmc_pkg::ADDR_POWER_SAVING, 8'h80);
		write_reg(rmc_pkg::ADDR_CLOCK_OVERRIDE, 8'h41);
		write_reg(rmc_pkg::ADDR_CLOCK_ENABLE, 8'h41);
	endtask : init_after_reset
	// Valid flags of all four bytes are folded into the top bit.
	task automatic read_serial_id(output logic [32:0] got);
		logic [8:0] b;
		got = {1'b1, 32'h0000_0000};
		set_analog(analog_o.write_en, 1'b1);
		for (int i = 0; i < 4; i++) begin
			read_reg(rmc_pkg::ADDR_SERIAL_ID_B0 + 6'(i), b);
			got[32] = got[32] & b[8];
			got[8*i +: 8] = b[7:0];
		end
		set_analog(analog_o.write_en, 1'b0);
	endtask : read_serial_id
endmodule : rmc_host_model

/* tb/test_radio_misc_config_registers.sv */
`timescale 1ns/10ps
module test_radio_misc_config_registers;
	localparam logic [15:0] STEP = 16'h0002;
	localparam logic [29:0] ID   = 30'h3fed_cba9;
	logic                 clock_i = 1'b0;
	logic                 reset_i = 1'b1;
	rmc_pkg::rmc_req_t    req;
	rmc_pkg::rmc_analog_t analog;
	logic                 manual_synth = 1'b0;
	logic                 pll_used = 1'b0;
	logic                 pll_lock = 1'b0;
	logic                 start = 1'b0;
	logic                 raw_cd = 1'b0;
	logic [7:0]           rd_data, clk_ovr, clk_en, lock_delay;
	logic                 rd_valid, power_save, carrier, locked;
	logic [8:0]           got;
	logic [32:0]          id_got;
	int                   num_errors = 0;
	int                   samples_checked = 0;
	int                   n;
	always #20 clock_i = ~clock_i;
	rmc_config_bank #(.LOCK_STEP_CYCLES(STEP)) u_rmc_config_bank (.clock_i(clock_i),
		.reset_i(reset_i), .req_i(req), .analog_i(analog), .manual_synth_i(manual_synth),
		.pll_lock_used_i(pll_used), .pll_lock_i(pll_lock), .synth_start_i(start),
		.carrier_detect_raw_i(raw_cd), .serial_id_i(ID), .rd_data_o(rd_data),
		.rd_valid_o(rd_valid), .power_save_o(power_save), .carrier_detect_o(carrier),
		.clock_override_o(clk_ovr), .clock_enable_o(clk_en), .lock_delay_o(lock_delay),
		.synth_locked_o(locked));
	rmc_host_model u_rmc_host_model (.clock_i(clock_i), .rd_data_i(rd_data),
		.rd_valid_i(rd_valid), .req_o(req), .analog_o(analog));
	// ======================================================================
	// Checking and closing.
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task automatic cycles(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask : cycles
	task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
		u_rmc_host_model.read_reg(a, got);
		check(what, 33'(got), {24'h0, 1'b1, exp});
	endtask : rd
	// ======================================================================
	// Tests.
	initial begin
		repeat (20) @(posedge clock_i);
		#1;
		reset_i = 1'b0;
		check("delay reset", 33'(lock_delay), 33'h64);
		check("clock outs reset", 33'({clk_ovr, clk_en}), 33'h0);
		rd(rmc_pkg::ADDR_LOCK_DELAY, 8'h64, "delay read");
		rd(rmc_pkg::ADDR_CLOCK_ENABLE, 8'h00, "enable read");
		$display("test reset done");
		u_rmc_host_model.write_reg(rmc_pkg::ADDR_POWER_SAVING, 8'h80);
		check("save blocked", 33'(power_save), 33'h0);
		u_rmc_host_model.write_reg(rmc_pkg::ADDR_CARRIER_DETECT, 8'h80);
		check("override blocked", 33'(carrier), 33'h0);
		u_rmc_host_model.init_after_reset();
		check("save on", 33'(power_save), 33'h1);
		rd(rmc_pkg::ADDR_POWER_SAVING, 8'h80, "save read");
		check("clock outs", 33'({clk_ovr, clk_en}), 33'h4141);
		rd(rmc_pkg::ADDR_CLOCK_OVERRIDE, 8'h41, "override read");
		$display("test init done");
		raw_cd = 1'b1;
		cycles(2);
		check("raw passes", 33'(carrier), 33'h1);
		raw_cd = 1'b0;
		cycles(2);
		check("raw clear", 33'(carrier), 33'h0);
		u_rmc_host_model.write_reg(rmc_pkg::ADDR_CARRIER_DETECT, 8'hff);
		cycles(1);
		check("forced", 33'(carrier), 33'h1);
		rd(rmc_pkg::ADDR_CARRIER_DETECT, 8'h80, "cd read");
		u_rmc_host_model.write_reg(rmc_pkg::ADDR_POWER_SAVING, 8'h7f);
		check("save off", 33'(power_save), 33'h0);
		rd(rmc_pkg::ADDR_POWER_SAVING, 8'h00, "reserved read");
		rd(6'h10, 8'h00, "unmapped read");
		$display("test fields done");
		for (int i = 0; i < 4; i++)
			rd(rmc_pkg::ADDR_SERIAL_ID_B0 + 6'(i), 8'h00, "gated id");
		u_rmc_host_model.read_serial_id(id_got);
		check("id", id_got, {1'b1, 2'b00, ID});
		for (int i = 0; i < 4; i++)
			u_rmc_host_model.write_reg(rmc_pkg::ADDR_SERIAL_ID_B0 + 6'(i), 8'h00);
		u_rmc_host_model.read_serial_id(id_got);
		check("id after write", id_got, {1'b1, 2'b00, ID});
		check("id enable off", 33'(analog.id_read_en), 33'h0);
		$display("test id done");
		// Only counts 0 and 3 are tried; larger counts just scale the same timer.
		for (int k = 0; k < 2; k++) begin
			u_rmc_host_model.write_reg(rmc_pkg::ADDR_LOCK_DELAY, k ? 8'h03 : 8'h00);
			start = 1'b1;
			cycles(1);
			start = 1'b0;
			n = 0;
			while (locked !== 1'b1 && n < 100) begin
				cycles(1);
				n++;
			end
			check("lock wait", 33'(n), 33'((k ? 3 : 0) * STEP + 1));
		end
		manual_synth = 1'b1;
		cycles(5);
		check("pll low", 33'(locked), 33'h0);
		pll_lock = 1'b1;
		cycles(2);
		check("pll early", 33'(locked), 33'h0);
		cycles(1);
		check("pll high", 33'(locked), 33'h1);
		manual_synth = 1'b0;
		pll_used = 1'b1;
		pll_lock = 1'b0;
		cycles(3);
		check("pll used low", 33'(locked), 33'h0);
		$display("test lock done");
		tally_and_finish();
	end
	initial begin
		repeat (3000) @(posedge clock_i);
		num_errors++;
		tally_and_finish();
	end
endmodule : test_radio_misc_config_registers
